// >>> hw/cosq_map.vh
// Constants for the controller operating mode sequencer
`ifndef COSQ_MAP_VH
`define COSQ_MAP_VH

// ====================================================
// Clock and time base
`define COSQ_CLK_HZ 125000000
`define COSQ_TICK_CYC (`COSQ_CLK_HZ / 1000)
`define COSQ_DEB_MS 5'd20
`define COSQ_WDOG_MS 7'd100
`define COSQ_CYC_MIN_MS 16'd1
`define COSQ_ARM_MS 12'd3000
`define COSQ_MR_WIN_MS 12'd3000
`define COSQ_START_BLINK_MS 12'd3000

// ====================================================
// Breakpoints and defaults
`define COSQ_BP_MAX 2'h3
`define COSQ_STEP_BP_MAX 2'h2
`define COSQ_STATION_DEF 8'h02

// ====================================================
// Analog channel modes and safe codes
`define COSQ_ANA_VOLT 2'h0
`define COSQ_ANA_I020 2'h1
`define COSQ_ANA_I420 2'h2
`define COSQ_SAFE_0V 16'h0000
`define COSQ_SAFE_0MA 16'h0000
`define COSQ_SAFE_4MA 16'h1999

`endif

// >>> hw/cosq_tick.v
// Millisecond tick prescaler
`timescale 1ns/10ps
module cosq_tick #(
  parameter TICK_CYC = 125000
) (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  input wire clk_en,
  // Tick
  output reg ms_tick_ff
);

  reg [16:0] cnt_ff;

  always @(posedge sys_clk) begin
    if (srst) begin
      cnt_ff <= 17'h00000;
      ms_tick_ff <= 1'b0;
    end else if (clk_en) begin
      if (cnt_ff == TICK_CYC[16:0] - 17'h00001) begin
        cnt_ff <= 17'h00000;
        ms_tick_ff <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 17'h00001;
        ms_tick_ff <= 1'b0;
      end
    end
  end

endmodule // cosq_tick

// >>> hw/cosq_debounce.v
// Two-stage synchroniser and debouncer for one switch contact
`timescale 1ns/10ps
`include "cosq_map.vh"
module cosq_debounce (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  input wire clk_en,
  input wire ms_tick,
  // Contact
  input wire raw,
  output reg clean_ff
);

  reg sync1_ff;
  reg sync2_ff;
  reg [4:0] cnt_ff;

  // ====================================================
  // Level must stay stable for the whole window
  always @(posedge sys_clk) begin
    if (srst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      cnt_ff <= 5'h00;
      clean_ff <= 1'b0;
    end else if (clk_en) begin
      sync1_ff <= raw;
      sync2_ff <= sync1_ff;
      if (sync2_ff == clean_ff) begin
        cnt_ff <= 5'h00;
      end else if (ms_tick) begin
        if (cnt_ff == `COSQ_DEB_MS - 5'h01) begin
          cnt_ff <= 5'h00;
          clean_ff <= sync2_ff;
        end else begin
          cnt_ff <= cnt_ff + 5'h01;
        end
      end
    end
  end

endmodule // cosq_debounce

// >>> hw/cosq_top.v
// Operating mode sequencer: run, stop, hold, start-up and memory reset
`timescale 1ns/10ps
`include "cosq_map.vh"
module cosq_top #(
  parameter TICK_CYC = `COSQ_TICK_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  input wire clk_en,
  // Mode switch contacts
  input wire sw_run_pos,
  input wire sw_memory_reset_position,
  // Host debugger
  input wire bp_set,
  input wire bp_clear_all,
  input wire dbg_step,
  input wire dbg_resume,
  // Program execution engine
  input wire bp_hit,
  input wire startup_block_done,
  input wire main_block_done,
  input wire wd_kick,
  input wire [15:0] cyc_limit_ms,
  // Memory and card
  input wire mem_erase_done,
  input wire autoload_present,
  input wire autoload_done,
  input wire factory_reset_req,
  input wire station_wr,
  input wire [7:0] station_wr_data,
  // Process image
  input wire [7:0] dout_image,
  input wire [7:0] dout_subst,
  input wire subst_en,
  input wire [7:0] remote_in,
  input wire [31:0] ana_image,
  input wire [31:0] ana_subst,
  input wire [3:0] ana_mode,
  // Sequencing strobes
  output reg input_image_clear_ff,
  output reg startup_block_go_ff,
  output reg output_image_clear_ff,
  output reg input_image_read_ff,
  output reg cyclic_main_block_go_ff,
  output reg output_image_write_ff,
  output reg step_go_ff,
  output reg step_refused_ff,
  output reg bp_refused_ff,
  output reg [1:0] bp_count_ff,
  output reg regs_expose_ff,
  output reg timer_tick_ff,
  output reg [31:0] rtc_ms_ff,
  output reg conn_keep_ff,
  // Supervision
  output reg wd_trip_ff,
  output reg cyc_trip_ff,
  // Outputs
  output reg command_output_disable_ff,
  output reg [7:0] dout_ff,
  output reg [31:0] ana_out_ff,
  output reg [7:0] remote_in_ff,
  // Memory and card
  output reg mem_erase_ff,
  output reg card_write_block_ff,
  output reg autoload_go_ff,
  output reg [7:0] station_addr_ff,
  // Indicators
  output reg run_indicator_ff,
  output reg stop_indicator_ff,
  output reg card_activity_indicator_ff,
  // Status
  output reg [3:0] mode_state_ff
);

  // ====================================================
  // States
  localparam ST_STOP = 4'h0;
  localparam ST_ICLR = 4'h1;
  localparam ST_START = 4'h2;
  localparam ST_OCLR = 4'h3;
  localparam ST_READ = 4'h4;
  localparam ST_EXEC = 4'h5;
  localparam ST_WRITE = 4'h6;
  localparam ST_HOLD = 4'h7;
  localparam ST_ERASE = 4'h8;
  localparam ST_LOAD = 4'h9;

  wire ms_tick;
  wire run_db;
  wire mr_db;
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [7:0] blink_ff;
  reg [6:0] wd_ms_ff;
  reg [15:0] cyc_ms_ff;
  reg [11:0] start_ms_ff;
  reg [11:0] mr_ms_ff;
  reg mr_prev_ff;
  reg mr_armed_ff;
  reg mr_ready_ff;
  reg fault_ff;
  reg factory_ff;

  // ====================================================
  // Time base and switch conditioning
  cosq_tick #(
    .TICK_CYC(TICK_CYC)
  ) u_tick (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .ms_tick_ff(ms_tick)
  );

  cosq_debounce u_deb_run (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .ms_tick(ms_tick),
    .raw(sw_run_pos),
    .clean_ff(run_db)
  );

  cosq_debounce u_deb_mr (
    .sys_clk(sys_clk),
    .srst(srst),
    .clk_en(clk_en),
    .ms_tick(ms_tick),
    .raw(sw_memory_reset_position),
    .clean_ff(mr_db)
  );

  // ====================================================
  // Supervision and derived conditions
  wire in_cycle = (state_ff == ST_OCLR) || (state_ff == ST_READ) ||
                  (state_ff == ST_EXEC) || (state_ff == ST_WRITE);
  wire in_run = in_cycle || (state_ff == ST_ICLR) ||
                (state_ff == ST_START) || (state_ff == ST_HOLD);
  wire [15:0] cyc_lim = (cyc_limit_ms < `COSQ_CYC_MIN_MS) ?
                        `COSQ_CYC_MIN_MS : cyc_limit_ms;
  wire wd_exp = in_cycle && (wd_ms_ff >= `COSQ_WDOG_MS);
  wire cyc_exp = in_cycle && (cyc_ms_ff >= cyc_lim);
  wire mr_fall = mr_prev_ff && !mr_db;
  wire mr_go = (state_ff == ST_STOP) &&
               ((mr_fall && mr_ready_ff &&
                 (mr_ms_ff < `COSQ_MR_WIN_MS)) ||
                factory_reset_req);
  wire step_ok = (bp_count_ff <= `COSQ_STEP_BP_MAX);
  wire slow = blink_ff[7];
  wire fast = blink_ff[5];

  // ====================================================
  // Next state
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_STOP: begin
        if (mr_go) begin
          nxt_state = ST_ERASE;
        end else if (run_db && !mr_db && !fault_ff) begin
          nxt_state = ST_ICLR;
        end
      end
      ST_ICLR: begin
        nxt_state = ST_START;
      end
      ST_START: begin
        if (startup_block_done) begin
          nxt_state = ST_OCLR;
        end
      end
      ST_OCLR: begin
        nxt_state = ST_READ;
      end
      ST_READ: begin
        nxt_state = ST_EXEC;
      end
      ST_EXEC: begin
        if (bp_hit && (bp_count_ff != 2'h0)) begin
          nxt_state = ST_HOLD;
        end else if (main_block_done) begin
          nxt_state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        nxt_state = ST_READ;
      end
      ST_HOLD: begin
        if (dbg_resume) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_ERASE: begin
        if (mem_erase_done) begin
          nxt_state = autoload_present ? ST_LOAD : ST_STOP;
        end
      end
      ST_LOAD: begin
        if (autoload_done) begin
          nxt_state = ST_STOP;
        end
      end
      default: begin
        nxt_state = ST_STOP;
      end
    endcase
    // Leaving run wins over every sequencing step
    if (in_run && (!run_db || wd_exp || cyc_exp)) begin
      nxt_state = ST_STOP;
    end
  end

  // ====================================================
  // Sequencer, counters and strobes
  always @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= ST_STOP;
      blink_ff <= 8'h00;
      wd_ms_ff <= 7'h00;
      cyc_ms_ff <= 16'h0000;
      start_ms_ff <= 12'h000;
      mr_ms_ff <= 12'h000;
      mr_prev_ff <= 1'b0;
      mr_armed_ff <= 1'b0;
      mr_ready_ff <= 1'b0;
      fault_ff <= 1'b0;
      factory_ff <= 1'b0;
      input_image_clear_ff <= 1'b0;
      startup_block_go_ff <= 1'b0;
      output_image_clear_ff <= 1'b0;
      input_image_read_ff <= 1'b0;
      cyclic_main_block_go_ff <= 1'b0;
      output_image_write_ff <= 1'b0;
      step_go_ff <= 1'b0;
      step_refused_ff <= 1'b0;
      bp_refused_ff <= 1'b0;
      bp_count_ff <= 2'h0;
      regs_expose_ff <= 1'b0;
      timer_tick_ff <= 1'b0;
      rtc_ms_ff <= 32'h00000000;
      conn_keep_ff <= 1'b1;
      wd_trip_ff <= 1'b0;
      cyc_trip_ff <= 1'b0;
      mem_erase_ff <= 1'b0;
      card_write_block_ff <= 1'b0;
      autoload_go_ff <= 1'b0;
      station_addr_ff <= `COSQ_STATION_DEF;
      mode_state_ff <= ST_STOP;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      mode_state_ff <= nxt_state;
      mr_prev_ff <= mr_db;
      if (ms_tick) begin
        blink_ff <= blink_ff + 8'h01;
        rtc_ms_ff <= rtc_ms_ff + 32'h00000001;
      end
      // Program timers only tick while code may run
      timer_tick_ff <= ms_tick && in_cycle && (nxt_state != ST_HOLD);
      conn_keep_ff <= 1'b1;

      // Sequencing strobes follow the state being entered
      input_image_clear_ff <= (nxt_state == ST_ICLR);
      startup_block_go_ff <= (nxt_state == ST_START);
      output_image_clear_ff <= (nxt_state == ST_OCLR);
      input_image_read_ff <= (nxt_state == ST_READ);
      cyclic_main_block_go_ff <= (nxt_state == ST_EXEC);
      output_image_write_ff <= (nxt_state == ST_WRITE);
      regs_expose_ff <= (nxt_state == ST_HOLD);

      // Breakpoint table: clear all wins over a set
      bp_refused_ff <= 1'b0;
      if (bp_clear_all || (state_ff == ST_ERASE)) begin
        bp_count_ff <= 2'h0;
      end else if (bp_set) begin
        if (bp_count_ff == `COSQ_BP_MAX) begin
          bp_refused_ff <= 1'b1;
        end else begin
          bp_count_ff <= bp_count_ff + 2'h1;
        end
      end

      // Single step from hold
      step_go_ff <= (state_ff == ST_HOLD) && (nxt_state == ST_HOLD) &&
                    dbg_step && step_ok;
      step_refused_ff <= (state_ff == ST_HOLD) && dbg_step &&
                         !step_ok;

      // Watchdog: cleared in hold, restarted by the program
      if (!in_cycle || wd_kick) begin
        wd_ms_ff <= 7'h00;
      end else if (ms_tick && (wd_ms_ff < `COSQ_WDOG_MS)) begin
        wd_ms_ff <= wd_ms_ff + 7'h01;
      end
      // Cycle time restarts with each input read
      if (!in_cycle || (state_ff == ST_READ)) begin
        cyc_ms_ff <= 16'h0000;
      end else if (ms_tick && (cyc_ms_ff != 16'hffff)) begin
        cyc_ms_ff <= cyc_ms_ff + 16'h0001;
      end

      // Trip latches the fault until the switch is put to stop
      if (wd_exp) begin
        wd_trip_ff <= 1'b1;
      end else if (!run_db || (state_ff == ST_ERASE)) begin
        wd_trip_ff <= 1'b0;
      end
      if (cyc_exp) begin
        cyc_trip_ff <= 1'b1;
      end else if (!run_db || (state_ff == ST_ERASE)) begin
        cyc_trip_ff <= 1'b0;
      end
      if (wd_exp || cyc_exp) begin
        fault_ff <= 1'b1;
      end else if (!run_db || (state_ff == ST_ERASE)) begin
        fault_ff <= 1'b0;
      end

      // Start-up blink runs on even if start-up aborts
      if (nxt_state == ST_START && state_ff != ST_START) begin
        start_ms_ff <= `COSQ_START_BLINK_MS;
      end else if (ms_tick && (start_ms_ff != 12'h000)) begin
        start_ms_ff <= start_ms_ff - 12'h001;
      end

      // Reset position timing, only meaningful in stop
      if (state_ff != ST_STOP) begin
        mr_ms_ff <= 12'h000;
        mr_armed_ff <= 1'b0;
        mr_ready_ff <= 1'b0;
      end else if (mr_db && !mr_prev_ff) begin
        mr_ms_ff <= 12'h000;
      end else if (mr_db && ms_tick && (mr_ms_ff != 12'hfff)) begin
        mr_ms_ff <= mr_ms_ff + 12'h001;
        if (mr_ms_ff == `COSQ_ARM_MS - 12'h001) begin
          mr_armed_ff <= 1'b1;
        end
      end
      if ((state_ff == ST_STOP) && mr_fall && mr_armed_ff) begin
        mr_ready_ff <= 1'b1;
      end

      // Memory reset and autoload; card writes blocked during erase and load
      if (mr_go) begin
        factory_ff <= factory_reset_req;
      end
      mem_erase_ff <= (nxt_state == ST_ERASE);
      card_write_block_ff <= (nxt_state == ST_ERASE) ||
                             (nxt_state == ST_LOAD);
      autoload_go_ff <= (nxt_state == ST_LOAD);
      if ((state_ff == ST_ERASE) && mem_erase_done && factory_ff) begin
        station_addr_ff <= `COSQ_STATION_DEF;
      end else if (station_wr) begin
        station_addr_ff <= station_wr_data;
      end
    end
  end

  // ====================================================
  // Output stage and indicators
  wire out_live = (nxt_state == ST_OCLR) || (nxt_state == ST_READ) ||
                  (nxt_state == ST_EXEC) || (nxt_state == ST_WRITE);
  reg [31:0] nxt_ana;
  reg [15:0] safe;
  integer ch;

  // One substitute enable serves both channels on purpose
  always @* begin
    nxt_ana = 32'h00000000;
    safe = `COSQ_SAFE_0V;
    for (ch = 0; ch < 2; ch = ch + 1) begin
      case (ana_mode[ch*2 +: 2])
        `COSQ_ANA_VOLT: safe = `COSQ_SAFE_0V;
        `COSQ_ANA_I020: safe = `COSQ_SAFE_0MA;
        `COSQ_ANA_I420: safe = `COSQ_SAFE_4MA;
        default: safe = `COSQ_SAFE_0V;
      endcase
      if (out_live) begin
        nxt_ana[ch*16 +: 16] = ana_image[ch*16 +: 16];
      end else if (subst_en) begin
        nxt_ana[ch*16 +: 16] = ana_subst[ch*16 +: 16];
      end else begin
        nxt_ana[ch*16 +: 16] = safe;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      command_output_disable_ff <= 1'b1;
      dout_ff <= 8'h00;
      ana_out_ff <= 32'h00000000;
      remote_in_ff <= 8'h00;
      run_indicator_ff <= 1'b0;
      stop_indicator_ff <= 1'b1;
      card_activity_indicator_ff <= 1'b0;
    end else if (clk_en) begin
      command_output_disable_ff <= !out_live;
      if (out_live) begin
        dout_ff <= dout_image;
      end else begin
        dout_ff <= subst_en ? dout_subst : 8'h00;
      end
      ana_out_ff <= nxt_ana;
      // Remote station is polled in every mode
      if (ms_tick) begin
        remote_in_ff <= remote_in;
      end
      card_activity_indicator_ff <= (nxt_state == ST_LOAD);
      case (nxt_state)
        ST_STOP: begin
          run_indicator_ff <= (start_ms_ff != 12'h000) && slow;
          stop_indicator_ff <= (mr_db && !mr_armed_ff) ? slow :
                               1'b1;
        end
        ST_ICLR, ST_START: begin
          run_indicator_ff <= slow;
          stop_indicator_ff <= 1'b1;
        end
        ST_HOLD: begin
          run_indicator_ff <= slow;
          stop_indicator_ff <= 1'b1;
        end
        ST_ERASE: begin
          run_indicator_ff <= 1'b0;
          stop_indicator_ff <= fast;
        end
        ST_LOAD: begin
          run_indicator_ff <= 1'b0;
          stop_indicator_ff <= 1'b1;
        end
        default: begin
          run_indicator_ff <= (start_ms_ff != 12'h000) ? slow :
                              1'b1;
          stop_indicator_ff <= 1'b0;
        end
      endcase
    end
  end

endmodule // cosq_top

// >>> tb/cosq_asserts.sv
// Port checks for the operating mode sequencer
`timescale 1ns/10ps
module cosq_asserts (
  // Clock and control
  input logic sys_clk,
  input logic srst,
  input logic clk_en,
  // Requests
  input logic bp_set,
  input logic bp_clear_all,
  input logic dbg_step,
  input logic dbg_resume,
  input logic bp_hit,
  input logic main_block_done,
  input logic subst_en,
  input logic [7:0] dout_subst,
  // Sequencer outputs
  input logic input_image_clear_ff,
  input logic startup_block_go_ff,
  input logic output_image_clear_ff,
  input logic input_image_read_ff,
  input logic cyclic_main_block_go_ff,
  input logic output_image_write_ff,
  input logic step_go_ff,
  input logic step_refused_ff,
  input logic bp_refused_ff,
  input logic [1:0] bp_count_ff,
  input logic regs_expose_ff,
  input logic conn_keep_ff,
  input logic command_output_disable_ff,
  input logic [7:0] dout_ff,
  input logic stop_indicator_ff,
  input logic mem_erase_ff,
  input logic card_write_block_ff,
  input logic [3:0] mode_state_ff
);
  // ======
  // Properties
  default clocking @(posedge sys_clk); endclocking
  // Frozen clock enable stalls the sequence, so skip those cycles
  default disable iff (srst || !clk_en);
  wire in_hold = mode_state_ff == 4'h7;
  property p_hold_out;
    in_hold |-> command_output_disable_ff && regs_expose_ff
      && !cyclic_main_block_go_ff && conn_keep_ff;
  endproperty
  a_hold_out: assert property (p_hold_out)
    else $error("hold with program or outputs live");
  property p_hold_lamp;
    in_hold |-> stop_indicator_ff;
  endproperty
  a_hold_lamp: assert property (p_hold_lamp)
    else $error("stop lamp dark in hold");
  property p_step_no;
    in_hold && dbg_step && !dbg_resume && bp_count_ff == 2'h3
      |=> step_refused_ff && !step_go_ff;
  endproperty
  a_step_no: assert property (p_step_no)
    else $error("step not refused with three breakpoints");
  property p_step_go;
    in_hold && dbg_step && !dbg_resume && bp_count_ff != 2'h3
      |=> step_go_ff && !step_refused_ff;
  endproperty
  a_step_go: assert property (p_step_go)
    else $error("step request not carried out");
  property p_bp_full;
    bp_count_ff == 2'h3 && bp_set && !bp_clear_all
      |=> bp_refused_ff && bp_count_ff == 2'h3;
  endproperty
  a_bp_full: assert property (p_bp_full)
    else $error("fourth breakpoint accepted");
  property p_startup;
    input_image_clear_ff |=> startup_block_go_ff && mode_state_ff == 4'h2;
  endproperty
  a_startup: assert property (p_startup)
    else $error("start-up block not after input clear");
  property p_release;
    output_image_clear_ff |-> !command_output_disable_ff
      ##1 input_image_read_ff ##1 cyclic_main_block_go_ff;
  endproperty
  a_release: assert property (p_release)
    else $error("start-up tail out of order");
  property p_cycle;
    mode_state_ff == 4'h5 && main_block_done && !bp_hit
      |=> output_image_write_ff ##1 input_image_read_ff;
  endproperty
  a_cycle: assert property (p_cycle)
    else $error("run cycle out of order");
  property p_stop_out;
    mode_state_ff != 4'h0 && mode_state_ff < 4'h8 ##1 mode_state_ff == 4'h0
      |-> command_output_disable_ff
      && dout_ff == (subst_en ? dout_subst : 8'h00);
  endproperty
  a_stop_out: assert property (p_stop_out)
    else $error("outputs live after stop");
  property p_erase;
    mode_state_ff == 4'h8 |-> mem_erase_ff && card_write_block_ff;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase without card protection");
  c_hold: cover property (in_hold && dbg_step);
  c_bp_full: cover property (bp_refused_ff);
  c_erase: cover property (mode_state_ff == 4'h8);
endmodule // cosq_asserts

bind cosq_top cosq_asserts u_chk (.*);

// >>> tb/cosq_switch_model.sv
// Mode switch model with contact chatter
`timescale 1ns/10ps
module cosq_switch_model (
  // Clock
  input wire logic sys_clk,
  // Position: 0 stop, 1 run, 2 memory reset
  input wire logic [1:0] pos,
  // Contacts
  output logic sw_run_pos = 1'h0,
  output logic sw_memory_reset_position = 1'h0
);
  // ======
  // Contacts
  logic [1:0] last_ff = 2'h0;
  logic [3:0] bounce_ff = 4'h0;
  // A closing contact chatters, so the block must debounce it
  always @(posedge sys_clk) begin
    last_ff <= pos;
    bounce_ff <= (pos != last_ff) ? 4'hf : bounce_ff - {3'h0, |bounce_ff};
    sw_run_pos <= pos == 2'h1 && !bounce_ff[0];
    sw_memory_reset_position <= pos == 2'h2 && !bounce_ff[0];
  end
endmodule // cosq_switch_model

// >>> tb/testbench.sv
// Self-checking bench for the mode sequencer
`timescale 1ns/10ps
`include "cosq_map.vh"
module testbench;
  // ======
  // Signals
  typedef struct packed {
    logic [3:0] mode;
    logic sub;
    logic [31:0] ana;
    logic [7:0] dout;
  } cosq_row_t;
  logic sys_clk = 1'h0, srst = 1'h1, clk_en = 1'h1, subst_en = 1'h0;
  logic [1:0] pos = 2'h0;
  logic sw_run_pos, sw_memory_reset_position;
  logic bp_set = 1'h0, bp_clear_all = 1'h0, dbg_step = 1'h0;
  logic dbg_resume = 1'h0, bp_hit = 1'h0, startup_block_done = 1'h1;
  logic main_block_done = 1'h0, wd_kick = 1'h1, mem_erase_done = 1'h0;
  logic autoload_present = 1'h0, autoload_done = 1'h0;
  logic factory_reset_req = 1'h0, station_wr = 1'h0;
  logic [7:0] station_wr_data = 8'h00, dout_image = 8'h00;
  logic [7:0] dout_subst = 8'ha5, remote_in = 8'h00;
  logic [15:0] cyc_limit_ms = 16'hffff;
  logic [31:0] ana_image = 32'h0, ana_subst = 32'h1234_5678;
  logic [3:0] ana_mode = 4'h0;
  logic input_image_clear_ff, startup_block_go_ff, output_image_clear_ff;
  logic input_image_read_ff, cyclic_main_block_go_ff, output_image_write_ff;
  logic step_go_ff, step_refused_ff, bp_refused_ff, regs_expose_ff;
  logic timer_tick_ff, conn_keep_ff, wd_trip_ff, cyc_trip_ff;
  logic command_output_disable_ff, mem_erase_ff, card_write_block_ff;
  logic autoload_go_ff, run_indicator_ff, stop_indicator_ff;
  logic card_activity_indicator_ff;
  logic [1:0] bp_count_ff;
  logic [31:0] rtc_ms_ff, ana_out_ff, t;
  logic [7:0] dout_ff, remote_in_ff, station_addr_ff;
  logic [3:0] mode_state_ff;
  int err_count = 0, checked = 0, n;
  cosq_row_t rows [5];
  // Short millisecond so the 3 s sequences stay brief
  cosq_top #(.TICK_CYC(10)) u_dut (.*);
  cosq_switch_model u_sw (.sys_clk, .pos, .sw_run_pos,
    .sw_memory_reset_position);
  initial forever #4 sys_clk = ~sys_clk;
  // ======
  // Tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task wait_mode(input logic [3:0] m);
    int i;
    i = 0;
    #1;
    while (mode_state_ff !== m && i < 5000) begin
      @(posedge sys_clk);
      #1;
      i++;
    end
    chk(mode_state_ff, m);
  endtask
  task hit(input logic [4:0] v);
    @(posedge sys_clk);
    {dbg_step, dbg_resume, bp_clear_all, mem_erase_done, autoload_done} <= v;
    @(posedge sys_clk);
    {dbg_step, dbg_resume, bp_clear_all, mem_erase_done, autoload_done}
      <= 5'h0;
    #1;
  endtask
  task end_of_test;
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #600000;
    err_count++;
    end_of_test;
  end
  // ======
  // Sequence
  initial begin
    rows[0] = '{4'h0, 1'h0, 32'h0, 8'h00};
    rows[1] = '{4'h9, 1'h0, {`COSQ_SAFE_4MA, `COSQ_SAFE_0MA}, 8'h00};
    rows[2] = '{4'h6, 1'h0, {`COSQ_SAFE_0MA, `COSQ_SAFE_4MA}, 8'h00};
    rows[3] = '{4'hf, 1'h0, {`COSQ_SAFE_0V, `COSQ_SAFE_0V}, 8'h00};
    rows[4] = '{4'h9, 1'h1, 32'h1234_5678, 8'ha5};
    repeat (5) @(posedge sys_clk);
    srst <= 1'h0;
    @(posedge sys_clk);
    #1 chk({mode_state_ff, command_output_disable_ff}, 5'h01);
    chk({stop_indicator_ff, run_indicator_ff}, 2'h2);
    chk(station_addr_ff, 8'h02);
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      ana_mode <= rows[i].mode;
      subst_en <= rows[i].sub;
      dout_image <= ~rows[i].dout;
      ana_image <= ~rows[i].ana;
      remote_in <= rows[i].dout ^ 8'h5a;
      main_block_done <= 1'h1;
      pos <= 2'h1;
      wait_mode(4'h5);
      chk(command_output_disable_ff, 1'h0);
      repeat (60) @(posedge sys_clk);
      main_block_done <= 1'h0;
      wait_mode(4'h5);
      @(posedge sys_clk) pos <= 2'h0;
      wait_mode(4'h0);
      chk(command_output_disable_ff, 1'h1);
      chk(dout_ff, rows[i].dout);
      chk(ana_out_ff, rows[i].ana);
      chk(remote_in_ff, rows[i].dout ^ 8'h5a);
    end
    @(posedge sys_clk);
    main_block_done <= 1'h1;
    pos <= 2'h1;
    bp_set <= 1'h1;
    repeat (4) @(posedge sys_clk);
    bp_set <= 1'h0;
    #1 chk({bp_refused_ff, bp_count_ff}, 3'h7);
    wait_mode(4'h5);
    @(posedge sys_clk) bp_hit <= 1'h1;
    wait_mode(4'h7);
    @(posedge sys_clk) bp_hit <= 1'h0;
    t = rtc_ms_ff;
    n = 0;
    repeat (40) begin
      @(posedge sys_clk);
      n += timer_tick_ff;
    end
    chk(n, 0);
    chk(rtc_ms_ff > t, 1'h1);
    @(posedge sys_clk) clk_en <= 1'h0;
    #1 t = rtc_ms_ff;
    repeat (30) @(posedge sys_clk);
    clk_en <= 1'h1;
    #1 chk(rtc_ms_ff, t);
    chk(mode_state_ff, 4'h7);
    chk({regs_expose_ff, cyclic_main_block_go_ff}, 2'h2);
    chk({command_output_disable_ff, conn_keep_ff}, 2'h3);
    chk(stop_indicator_ff, 1'h1);
    hit(5'h10);
    chk({step_refused_ff, step_go_ff}, 2'h2);
    hit(5'h04);
    chk(bp_count_ff, 2'h0);
    hit(5'h10);
    chk(step_go_ff, 1'h1);
    hit(5'h08);
    wait_mode(4'h5);
    @(posedge sys_clk);
    main_block_done <= 1'h0;
    wd_kick <= 1'h0;
    repeat (950) @(posedge sys_clk);
    #1 chk(mode_state_ff, 4'h5);
    wait_mode(4'h0);
    chk({wd_trip_ff, command_output_disable_ff}, 2'h3);
    @(posedge sys_clk) pos <= 2'h0;
    repeat (300) @(posedge sys_clk);
    wd_kick <= 1'h1;
    cyc_limit_ms <= 16'h0005;
    pos <= 2'h1;
    wait_mode(4'h5);
    chk(wd_trip_ff, 1'h0);
    repeat (30) @(posedge sys_clk);
    #1 chk(mode_state_ff, 4'h5);
    wait_mode(4'h0);
    chk(cyc_trip_ff, 1'h1);
    @(posedge sys_clk) pos <= 2'h0;
    repeat (300) @(posedge sys_clk);
    cyc_limit_ms <= 16'hffff;
    pos <= 2'h2;
    repeat (31000) @(posedge sys_clk);
    #1 chk(stop_indicator_ff, 1'h1);
    @(posedge sys_clk) pos <= 2'h0;
    repeat (300) @(posedge sys_clk);
    pos <= 2'h2;
    repeat (500) @(posedge sys_clk);
    pos <= 2'h0;
    autoload_present <= 1'h1;
    wait_mode(4'h8);
    chk({mem_erase_ff, card_write_block_ff}, 2'h3);
    n = 0;
    repeat (800) begin
      @(posedge sys_clk);
      n += stop_indicator_ff;
    end
    chk(n > 0 && n < 800, 1'h1);
    @(posedge sys_clk) pos <= 2'h1;
    hit(5'h02);
    wait_mode(4'h9);
    chk(card_activity_indicator_ff, 1'h1);
    hit(5'h01);
    chk({mode_state_ff, stop_indicator_ff}, 5'h01);
    wait_mode(4'h5);
    chk(card_activity_indicator_ff, 1'h0);
    @(posedge sys_clk) pos <= 2'h0;
    station_wr <= 1'h1;
    station_wr_data <= 8'h3c;
    autoload_present <= 1'h0;
    @(posedge sys_clk) station_wr <= 1'h0;
    wait_mode(4'h0);
    chk(station_addr_ff, 8'h3c);
    @(posedge sys_clk) factory_reset_req <= 1'h1;
    @(posedge sys_clk) factory_reset_req <= 1'h0;
    #1 chk(mode_state_ff, 4'h8);
    hit(5'h02);
    chk({mode_state_ff, station_addr_ff}, 12'h002);
    end_of_test;
  end
endmodule // testbench
